// File: src/spi_flag_pkg.sv
// Package: register map, field layout and types of the serial flag logic
package spi_flag_pkg;

    // Register offsets (byte addresses)
    localparam int             ADDR_W     = 8;
    localparam logic [7:0]     OFS_ENABLE = 8'h04;
    localparam logic [7:0]     OFS_STATUS = 8'h10;
    localparam logic [7:0]     OFS_CLEAR  = 8'h14;
    localparam logic [7:0]     OFS_DATA   = 8'h18;

    // Reset and read-back values
    localparam logic [7:0]     ENABLE_RESET   = 8'h00;
    localparam logic [31:0]    CLEAR_READBACK = 32'h000000FF;

    // Status and enable bit positions
    localparam int BIT_TX_EMPTY        = 0;
    localparam int BIT_RX_NOT_EMPTY    = 1;
    localparam int BIT_SEL_FALL        = 2;
    localparam int BIT_SEL_RISE        = 3;
    localparam int BIT_TX_UNDERRUN     = 4;
    localparam int BIT_RX_LOST         = 5;
    localparam int BIT_SEL_ERROR       = 6;
    localparam int BIT_MASTER_CONFLICT = 7;
    localparam int BIT_BUSY            = 8;
    localparam int BIT_SEL_LEVEL       = 9;
    localparam int FLAG_W              = 8;
    localparam int FRAME_W             = 16;

    // Link activity states
    typedef enum logic {LINK_IDLE, LINK_ACTIVE} link_state_t;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;   // Byte address
        logic [31:0]       wdata;  // Write data
        logic              wr;     // Write strobe
        logic              rd;     // Read strobe
    } reg_req_t;

    // Received frame from the shift engine
    typedef struct packed {
        logic               done;  // Frame complete pulse
        logic [FRAME_W-1:0] data;  // Frame contents
    } rx_frame_t;

    // Buffered transmit word towards the shift engine
    typedef struct packed {
        logic               valid; // Buffer holds a word
        logic [FRAME_W-1:0] data;  // Word to send
    } tx_word_t;

    // Whole state of the flag logic
    typedef struct packed {
        link_state_t        link;     // Transfer in progress or not
        logic [1:0]         sel_sync; // Select pin synchroniser
        logic               sel_prev; // Last synced select level
        logic [1:0]         sck_sync; // Link clock synchroniser
        logic               sck_prev; // Last synced link clock
        logic [FLAG_W-1:0]  enable;   // Interrupt enables
        logic [FLAG_W-1:1]  flags;    // Sticky flags
        logic               tx_full;  // Transmit buffer occupied
        logic [FRAME_W-1:0] tx_data;  // Transmit buffer
        logic [FRAME_W-1:0] rx_data;  // Receive buffer
        logic               purge;    // Flush pulse to shifter
        logic [31:0]        rdata;    // Read data register
    } state_t;

    // State after reset: select idle high, transmit buffer empty
    localparam state_t STATE_RESET = '{
        link: LINK_IDLE, sel_sync: 2'h3, sel_prev: 1'b1,
        sck_sync: 2'h0, sck_prev: 1'b0, enable: ENABLE_RESET,
        flags: 7'h00, tx_full: 1'b0, tx_data: 16'h0000,
        rx_data: 16'h0000, purge: 1'b0, rdata: 32'h00000000};

endpackage

// File: src/spi_flag_logic.sv
// Module: interrupt enable, status flags and flag clearing of the serial unit
//
// Overview of operation
// - Eight enable bits, one per event flag
// - Status bit 9 shows select line level
// - Status bit 8 high while transfer active
// - Master mode, select low sets conflict flag
// - Slave mode, select error sets bit 6
// - Receive overflow sets bit 5
// - Slave mode, transmit underflow sets bit 4
// - Select rising edge sets bit 3
// - Select falling edge sets bit 2
// - Receive data held; read or clear drops
// - Bit 0 high while transmit buffer empty
// - Writing zero clears flag; one does nothing
// - Clear register reads back 0xFF
// - Zero at clear bit 0 flushes transmit path
// - Data register, 16 bits, send and receive
`timescale 1ns/1ns
module spi_flag_logic
    import spi_flag_pkg::*;
#(
    parameter int DATA_W = FRAME_W  // Used frame width
) (
    input  wire logic      core_clk_in,    // Peripheral clock
    input  wire logic      reset_in,       // Async reset, high
    input  wire reg_req_t  bus_req_in,     // Register port request
    output logic [31:0]    read_data_out,  // Read data, cycle after
    input  wire logic      master_mode_in, // Unit is master
    input  wire logic      sel_pin_in,     // Select pin level
    input  wire logic      sck_pin_in,     // Link clock pin
    input  wire rx_frame_t rx_frame_in,    // Frame from shifter
    input  wire logic      tx_take_in,     // Shifter took the word
    output tx_word_t       tx_word_out,    // Word for the shifter
    output logic           tx_purge_out,   // Flush shift register
    output logic           irq_out         // Interrupt request
);

    // Frame width must fit the data path; refused while elaborating
    if (DATA_W < 1 || DATA_W > FRAME_W) begin : g_width_check
        $error("DATA_W out of range");
    end

    // Keeps only the used frame bits
    localparam logic [FRAME_W-1:0] DATA_MASK = FRAME_W'((32'h1 << DATA_W) - 32'h1);

    // Address decode shared by reads and writes
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    state_t            s_q;         // Registered state
    state_t            s_d;         // Next state
    logic              sel_lvl;     // Synced select level
    logic              sel_rise;    // Select rising edge
    logic              sel_fall;    // Select falling edge
    logic              sck_edge;    // Any link clock edge
    logic              xfer_start;  // First edge of a transfer
    logic              wr_enable;   // Write to enables
    logic              wr_clear;    // Write to clear register
    logic              wr_data;     // Write to data register
    logic              rd_data;     // Read of data register
    logic [FLAG_W-1:1] ev;          // Flag set events
    logic [FLAG_W-1:1] clr;         // Flag clear requests
    logic [31:0]       status_word; // Status register view

    // Edge and level detection on synced pins
    always_comb begin
        sel_lvl    = s_q.sel_sync[1];
        sel_rise   = sel_lvl & ~s_q.sel_prev;
        sel_fall   = ~sel_lvl & s_q.sel_prev;
        sck_edge   = s_q.sck_sync[1] ^ s_q.sck_prev;
        xfer_start = (s_q.link == LINK_IDLE) & sck_edge & (master_mode_in | ~sel_lvl);
    end

    // Register port decode
    always_comb begin
        wr_enable = bus_req_in.wr & reg_hit(bus_req_in.addr, OFS_ENABLE);
        wr_clear  = bus_req_in.wr & reg_hit(bus_req_in.addr, OFS_CLEAR);
        wr_data   = bus_req_in.wr & reg_hit(bus_req_in.addr, OFS_DATA);
        rd_data   = bus_req_in.rd & reg_hit(bus_req_in.addr, OFS_DATA);
    end

    // Status view: level, busy, flags, transmit empty
    always_comb begin
        status_word                   = 32'h00000000;
        status_word[BIT_SEL_LEVEL]    = sel_lvl;
        status_word[BIT_BUSY]         = (s_q.link == LINK_ACTIVE);
        status_word[FLAG_W-1:1]       = s_q.flags;
        status_word[BIT_TX_EMPTY]     = ~s_q.tx_full;
    end

    // Flag events and clears
    always_comb begin
        ev                      = '0;
        ev[BIT_MASTER_CONFLICT] = master_mode_in & ~sel_lvl;
        ev[BIT_SEL_ERROR]       = ~master_mode_in & sel_rise &
                                  (s_q.link == LINK_ACTIVE);
        ev[BIT_RX_LOST]         = rx_frame_in.done & s_q.flags[BIT_RX_NOT_EMPTY];
        ev[BIT_TX_UNDERRUN]     = ~master_mode_in & xfer_start & ~s_q.tx_full;
        ev[BIT_SEL_RISE]        = sel_rise;
        ev[BIT_SEL_FALL]        = sel_fall;
        ev[BIT_RX_NOT_EMPTY]    = rx_frame_in.done;
        // Zero in a clear bit clears, one is ignored
        clr = wr_clear ? ~bus_req_in.wdata[FLAG_W-1:1] : '0;
        if (rd_data) begin
            clr[BIT_RX_NOT_EMPTY] = 1'b1;
        end
    end

    // Next-state logic
    always_comb begin
        s_d = s_q;
        // Two-flop synchronisers, then edge history
        // Only the second stage is read: the first may still be settling
        // History starts at the idle pin levels, so reset brings no false edge
        s_d.sel_sync = {s_q.sel_sync[0], sel_pin_in};
        s_d.sel_prev = s_q.sel_sync[1];
        s_d.sck_sync = {s_q.sck_sync[0], sck_pin_in};
        s_d.sck_prev = s_q.sck_sync[1];

        // Sticky flags, set beats clear
        // A clear never hides an event of the same cycle
        for (int i = 1; i < FLAG_W; i++) begin
            s_d.flags[i] = ev[i] | (s_q.flags[i] & ~clr[i]);
        end

        // Link activity tracking
        case (s_q.link)
            LINK_IDLE: begin
                if (xfer_start) begin
                    s_d.link = LINK_ACTIVE;
                end
            end
            LINK_ACTIVE: begin
                if (rx_frame_in.done || (!master_mode_in && sel_lvl)) begin
                    s_d.link = LINK_IDLE;
                end
            end
            default: begin
                s_d.link = LINK_IDLE;
            end
        endcase

        // Enable register write
        if (wr_enable) begin
            s_d.enable = bus_req_in.wdata[FLAG_W-1:0];
        end

        // Received frame replaces buffer contents
        if (rx_frame_in.done) begin
            s_d.rx_data = rx_frame_in.data & DATA_MASK;
        end

        // Transmit buffer: take, then refill
        if (tx_take_in) begin
            s_d.tx_full = 1'b0;
        end
        if (wr_data) begin
            s_d.tx_data = bus_req_in.wdata[FRAME_W-1:0] & DATA_MASK;
            s_d.tx_full = 1'b1;
        end

        // Flush request empties buffer and shifter
        // A flush wins over a take of the same cycle
        s_d.purge = wr_clear & ~bus_req_in.wdata[BIT_TX_EMPTY];
        if (s_d.purge) begin
            s_d.tx_full = 1'b0;
        end

        // Read data, valid only in the next cycle
        // Zero between reads, so a stale word never looks valid
        s_d.rdata = 32'h00000000;
        if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                OFS_ENABLE: begin
                    s_d.rdata = {24'h000000, s_q.enable};
                end
                OFS_STATUS: begin
                    s_d.rdata = status_word;
                end
                OFS_CLEAR: begin
                    s_d.rdata = CLEAR_READBACK;
                end
                OFS_DATA: begin
                    s_d.rdata = {16'h0000, s_q.rx_data};
                end
                default: begin
                    s_d.rdata = 32'h00000000;  // Unmapped reads zero
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign read_data_out     = s_q.rdata;
    assign tx_word_out.valid = s_q.tx_full;
    assign tx_word_out.data  = s_q.tx_data;
    assign tx_purge_out      = s_q.purge;
    assign irq_out           = |(status_word[FLAG_W-1:0] & s_q.enable);

    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    // Enabled overflow raises the interrupt
    AST_IRQ_ON_FLAG: assert property (
        s_q.enable[BIT_RX_LOST] && s_q.flags[BIT_RX_LOST] |-> irq_out)
        else $error("enabled flag without interrupt");

    // Select low in master mode flags a conflict
    AST_MASTER_CONFLICT: assert property (
        master_mode_in && !s_q.sel_sync[1] |=> s_q.flags[BIT_MASTER_CONFLICT])
        else $error("master conflict not flagged");

    // Unread frame overwritten sets overflow
    AST_RX_OVERFLOW: assert property (
        rx_frame_in.done && s_q.flags[BIT_RX_NOT_EMPTY] |=> s_q.flags[BIT_RX_LOST])
        else $error("overflow not flagged");

    // Data read drops receive flag
    AST_RX_READ_CLEAR: assert property (
        rd_data && !rx_frame_in.done |=> !s_q.flags[BIT_RX_NOT_EMPTY])
        else $error("receive flag survived read");

    // Writing one to a clear bit keeps the flag
    AST_CLEAR_ONE_KEEPS: assert property (
        wr_clear && bus_req_in.wdata[BIT_RX_LOST] && s_q.flags[BIT_RX_LOST]
        |=> s_q.flags[BIT_RX_LOST])
        else $error("flag lost on write of one");

    // Flush pulses once and empties buffer
    AST_PURGE: assert property (
        wr_clear && !bus_req_in.wdata[BIT_TX_EMPTY]
        |=> tx_purge_out && !tx_word_out.valid
            ##1 (!tx_purge_out || $past(wr_clear && !bus_req_in.wdata[BIT_TX_EMPTY])))
        else $error("flush misbehaved");

    // Clear register reads back 0xFF
    AST_CLEAR_READBACK: assert property (
        bus_req_in.rd && bus_req_in.addr == OFS_CLEAR |=> read_data_out == CLEAR_READBACK)
        else $error("clear register read back wrong");

    // Status read shows empty and busy of the read cycle
    AST_STATUS_VIEW: assert property (
        bus_req_in.rd && bus_req_in.addr == OFS_STATUS
        |=> read_data_out[BIT_TX_EMPTY] == !$past(s_q.tx_full)
            && read_data_out[BIT_BUSY] == ($past(s_q.link) == LINK_ACTIVE))
        else $error("status view wrong");

    // Rising select sets its flag
    AST_SEL_RISE: assert property (
        $rose(s_q.sel_sync[1]) |=> s_q.flags[BIT_SEL_RISE])
        else $error("rise not flagged");

    // Falling select sets its flag
    AST_SEL_FALL: assert property (
        $fell(s_q.sel_sync[1]) |=> s_q.flags[BIT_SEL_FALL])
        else $error("fall not flagged");

    // Status read shows the synced select level
    AST_SEL_LEVEL: assert property (
        bus_req_in.rd && bus_req_in.addr == OFS_STATUS
        |=> read_data_out[BIT_SEL_LEVEL] == $past(s_q.sel_sync[1]))
        else $error("select level wrong");

    // Slave start with empty buffer flags underflow
    AST_UNDERRUN: assert property (
        !master_mode_in && xfer_start && !s_q.tx_full |=> s_q.flags[BIT_TX_UNDERRUN])
        else $error("underflow not flagged");

    // No underflow raised in master mode
    AST_NO_UNDERRUN_MASTER: assert property (
        master_mode_in && !s_q.flags[BIT_TX_UNDERRUN]
        |=> !s_q.flags[BIT_TX_UNDERRUN])
        else $error("underflow in master mode");

    // Select rising mid-transfer in slave mode
    AST_SEL_ERROR: assert property (
        !master_mode_in && $rose(s_q.sel_sync[1]) && s_q.link == LINK_ACTIVE
        |=> s_q.flags[BIT_SEL_ERROR])
        else $error("select error not flagged");

    // No select error raised in master mode
    AST_NO_SEL_ERROR_MASTER: assert property (
        master_mode_in && !s_q.flags[BIT_SEL_ERROR]
        |=> !s_q.flags[BIT_SEL_ERROR])
        else $error("select error in master mode");

    // First link clock edge makes the bus busy
    AST_BUSY_START: assert property (
        xfer_start |=> s_q.link == LINK_ACTIVE)
        else $error("busy not set");

    // Slave busy ends once select is high
    AST_BUSY_END: assert property (
        !master_mode_in && s_q.sel_sync[1] && s_q.link == LINK_ACTIVE
        |=> s_q.link == LINK_IDLE)
        else $error("busy not cleared");

    // High select never raises the conflict flag
    AST_NO_CONFLICT: assert property (
        s_q.sel_sync[1] && !s_q.flags[BIT_MASTER_CONFLICT]
        |=> !s_q.flags[BIT_MASTER_CONFLICT])
        else $error("conflict without low select");

    // Enable write lands in all eight bits
    AST_ENABLE_WRITE: assert property (
        wr_enable |=> s_q.enable == $past(bus_req_in.wdata[FLAG_W-1:0]))
        else $error("enable write lost");

    // Enable read returns the enables
    AST_ENABLE_READ: assert property (
        bus_req_in.rd && bus_req_in.addr == OFS_ENABLE
        |=> read_data_out[FLAG_W-1:0] == $past(s_q.enable))
        else $error("enable read wrong");

    // Frame sets receive flag and keeps its data
    AST_RX_STORE: assert property (
        rx_frame_in.done |=> s_q.flags[BIT_RX_NOT_EMPTY]
            && s_q.rx_data == $past(rx_frame_in.data & DATA_MASK))
        else $error("frame not stored");

    // Receive flag holds until read or cleared
    AST_RX_KEEP: assert property (
        s_q.flags[BIT_RX_NOT_EMPTY] && !rd_data && !wr_clear
        |=> s_q.flags[BIT_RX_NOT_EMPTY])
        else $error("receive flag dropped");

    // Data write fills the transmit buffer
    AST_TX_LOAD: assert property (
        wr_data |=> tx_word_out.valid
            && tx_word_out.data == $past(bus_req_in.wdata[FRAME_W-1:0] & DATA_MASK))
        else $error("transmit word wrong");

    // Take without refill empties the buffer
    AST_TX_TAKE: assert property (
        tx_take_in && !wr_data |=> !tx_word_out.valid)
        else $error("buffer still full after take");

    // Flush pulse only after a flush request
    AST_PURGE_CAUSE: assert property (
        tx_purge_out |-> $past(wr_clear && !bus_req_in.wdata[BIT_TX_EMPTY]))
        else $error("flush without request");

    // Zero in a clear bit drops that flag
    AST_CLEAR_ZERO: assert property (
        wr_clear && !bus_req_in.wdata[BIT_SEL_RISE] && !sel_rise
        |=> !s_q.flags[BIT_SEL_RISE])
        else $error("flag survived clear");

    // No enables, no interrupt
    AST_IRQ_MASKED: assert property (
        !(|s_q.enable) |-> !irq_out)
        else $error("interrupt while masked");

    // Read data is zero outside the answer cycle
    AST_READ_IDLE: assert property (
        !bus_req_in.rd |=> read_data_out == '0)
        else $error("read data without read");

    // Data read returns the received frame
    AST_DATA_READ: assert property (
        bus_req_in.rd && bus_req_in.addr == OFS_DATA
        |=> read_data_out[FRAME_W-1:0] == $past(s_q.rx_data))
        else $error("data read wrong");

    // Reserved status bits read zero
    AST_STATUS_UPPER: assert property (
        bus_req_in.rd && bus_req_in.addr == OFS_STATUS
        |=> read_data_out[31:BIT_SEL_LEVEL+1] == '0)
        else $error("reserved status bits set");

endmodule // spi_flag_logic

// File: sim/spi_peer_model.sv
// Serial peer model: drives the select line and link clock of one frame
`timescale 1ns/1ns
module spi_peer_model (
    input  wire logic frame_go_in,  // Rising edge starts a frame
    input  wire logic sel_hold_in,  // Holds select low while high
    output logic      sel_pin_out,  // Select, low active
    output logic      sck_pin_out   // Link clock, still between frames
);
    logic sel_q = 1'b1;  // Frame select level
    logic sck_q = 1'b0;  // Link clock level

    // Select pulled up when idle, held low on request
    assign sel_pin_out = sel_q & ~sel_hold_in;
    assign sck_pin_out = sck_q;

    // One frame: select low, four clock periods of 125 ns, select high
    always @(posedge frame_go_in) begin
        sel_q = 1'b0;
        #125;
        repeat (4) begin
            sck_q = 1'b1;
            #63;
            sck_q = 1'b0;
            #62;
        end
        #125;
        sel_q = 1'b1;
    end
endmodule // spi_peer_model

// File: sim/tb_spi_flag_logic.sv
// Testbench: flag logic driven by register tasks and a serial peer
`timescale 1ns/1ns
module tb_spi_flag_logic;
    import spi_flag_pkg::*;
    logic        core_clk_in = 1'b0;  // Core clock
    logic        reset_in    = 1'b1;  // Reset, high
    reg_req_t    req         = '0;    // Register request
    logic [31:0] rdata;               // Read data from design
    logic        master_mode = 1'b0;  // Master mode select
    logic        sel_pin;             // Select from peer
    logic        sck_pin;             // Link clock from peer
    rx_frame_t   rx_frame    = '0;    // Frame from shifter
    logic        tx_take     = 1'b0;  // Shifter take pulse
    tx_word_t    tx_word;             // Word to shifter
    logic        tx_purge;            // Flush pulse
    logic        irq;                 // Interrupt line
    logic        frame_go    = 1'b0;  // Starts a peer frame
    logic        sel_hold    = 1'b0;  // Peer holds select low
    int          errors      = 0;     // Mismatches
    int          tests_run   = 0;     // Comparisons
    logic [31:0] v;                   // Scratch value
    logic [31:0] e;                   // Expected value

    // 100 MHz clock
    always #5 core_clk_in = ~core_clk_in;

    spi_flag_logic #(.DATA_W(16)) u_dut (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .bus_req_in(req),
        .read_data_out(rdata), .master_mode_in(master_mode), .sel_pin_in(sel_pin),
        .sck_pin_in(sck_pin), .rx_frame_in(rx_frame), .tx_take_in(tx_take),
        .tx_word_out(tx_word), .tx_purge_out(tx_purge), .irq_out(irq));

    spi_peer_model u_peer (
        .frame_go_in(frame_go), .sel_hold_in(sel_hold),
        .sel_pin_out(sel_pin), .sck_pin_out(sck_pin));

    // Expected interrupt level from status and enables
    function automatic logic exp_irq(input logic [31:0] st, input logic [31:0] en);
        return |(st[7:0] & en[7:0]);
    endfunction

    // Compare and count
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One-cycle write; effects visible on return
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_in);
        req <= '0;
        #1;
    endtask

    // One-cycle read, data sampled in the following cycle
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        req <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_in);
        req <= '0;
        #1;
        chk(name, exp, rdata);
    endtask

    // Received-frame pulse from the shifter
    task automatic rx_pulse(input logic [15:0] d);
        @(posedge core_clk_in);
        rx_frame <= '{done: 1'b1, data: d};
        @(posedge core_clk_in);
        rx_frame <= '0;
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        $display("counts: %0d checks, %0d mismatches", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #20000;
        errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        v = $urandom(32'h3290);
        repeat (16) @(posedge core_clk_in);
        reset_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        rchk("status", OFS_STATUS, 32'h00000201);
        rchk("enable", OFS_ENABLE, 32'h00000000);
        rchk("clear", OFS_CLEAR, CLEAR_READBACK);
        rchk("unmapped", 8'h08, 32'h00000000);
        $display("test reset done");
        // Enables: first fixed, then random
        for (int i = 0; i < 5; i++) begin
            e = (i == 0) ? 32'h00000001 : ($urandom & 32'h000000FF);
            wr(OFS_ENABLE, e);
            chk("irq", {31'h0, exp_irq(32'h00000201, e)}, {31'h0, irq});
            rchk("enable", OFS_ENABLE, e);
        end
        wr(OFS_ENABLE, 32'h00000000);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test enable done");
        // Transmit buffer, take and purge
        e = $urandom & 32'h0000FFFF;
        wr(OFS_DATA, e);
        chk("tx_valid", 32'h1, {31'h0, tx_word.valid});
        chk("tx_data", e, {16'h0, tx_word.data});
        rchk("status", OFS_STATUS, 32'h00000200);
        @(posedge core_clk_in);
        tx_take <= 1'b1;
        @(posedge core_clk_in);
        tx_take <= 1'b0;
        rchk("status", OFS_STATUS, 32'h00000201);
        wr(OFS_DATA, $urandom & 32'h0000FFFF);
        wr(OFS_CLEAR, 32'h000000FE);
        chk("purge", 32'h1, {31'h0, tx_purge});
        chk("tx_valid", 32'h0, {31'h0, tx_word.valid});
        rchk("status", OFS_STATUS, 32'h00000201);
        $display("test transmit done");
        // Receive, read clears, overflow, write-zero clearing
        e = $urandom & 32'h0000FFFF;
        rx_pulse(e[15:0]);
        rchk("status", OFS_STATUS, 32'h00000203);
        rchk("data", OFS_DATA, e);
        rchk("status", OFS_STATUS, 32'h00000201);
        rx_pulse(16'($urandom));
        rx_pulse(16'($urandom));
        wr(OFS_ENABLE, 32'h00000020);
        chk("irq", 32'h1, {31'h0, irq});
        rchk("status", OFS_STATUS, 32'h00000223);
        wr(OFS_CLEAR, 32'h000000FF);
        rchk("status", OFS_STATUS, 32'h00000223);
        wr(OFS_CLEAR, 32'h000000DF);
        chk("irq", 32'h0, {31'h0, irq});
        rchk("status", OFS_STATUS, 32'h00000203);
        wr(OFS_CLEAR, 32'h000000FD);
        rchk("status", OFS_STATUS, 32'h00000201);
        $display("test receive done");
        // Slave frame from the peer with empty buffer
        @(posedge core_clk_in);
        frame_go <= 1'b1;
        repeat (30) @(posedge core_clk_in);
        rchk("status", OFS_STATUS, 32'h00000115);
        @(posedge core_clk_in);
        frame_go <= 1'b0;
        repeat (80) @(posedge core_clk_in);
        rchk("status", OFS_STATUS, 32'h0000025D);
        wr(OFS_CLEAR, 32'h00000001);
        rchk("status", OFS_STATUS, 32'h00000201);
        $display("test slave frame done");
        // Master mode with select driven low
        @(posedge core_clk_in);
        master_mode <= 1'b1;
        sel_hold <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        rchk("status", OFS_STATUS, 32'h00000085);
        @(posedge core_clk_in);
        sel_hold <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        wr(OFS_CLEAR, 32'h00000001);
        rchk("status", OFS_STATUS, 32'h00000201);
        $display("test master conflict done");
        // Reset in mid-run with a flag and all enables set
        rx_pulse(16'($urandom));
        wr(OFS_ENABLE, 32'h000000FF);
        chk("irq", {31'h0, exp_irq(32'h00000203, 32'h000000FF)}, {31'h0, irq});
        @(posedge core_clk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        rchk("status", OFS_STATUS, 32'h00000201);
        rchk("enable", OFS_ENABLE, 32'h00000000);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule // tb_spi_flag_logic
